//--- hdl/atp_pkg.sv
// Purpose: Shared constants and types for the conversion trigger pacer.
// Assumes: One clock domain, 250 MHz; all pins sampled synchronously.
// Notes:   Counter modes are a simplified programmable-timer subset.
//
// Contract
// - Three 16-bit counters, oscillator clocked
// - Counter one chains into counter two
// - Pacer rising edge starts one conversion
// - Pacer output driven onto external pin
// - Counter zero counts events or makes pulses
// - External trigger ignored while gate low
// - External trigger rising edge starts conversion
// - Software selects channel, 16 single or 8 diff
// - Counter zero clock external or internal selectable
// - External gate controls counter zero counting
package atp_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CNT_WIDTH       = 16;
  localparam int CHAN_SINGLE     = 16;
  localparam int CHAN_DIFF       = 8;
  localparam int CHAN_WIDTH      = 4;
  localparam int SYNC_STAGES     = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [3:0]  RST_CHAN  = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ATP_MODE_EVENT = 1'b0,
    ATP_MODE_PULSE = 1'b1
  } atp_mode_t;

  typedef struct packed {
    logic [15:0] reload;
    logic        load;
  } atp_cnt_cfg_t;

  typedef struct packed {
    logic       differential;
    logic [3:0] channel;
  } atp_chan_cfg_t;

endpackage

//--- hdl/atp_counter.sv
// Purpose: One 16-bit down counter with reload, gate and count enable.
// Assumes: Count enable is a strobe or a held level in the system clock domain.
// Notes:   Terminal pulse is one cycle wide, issued as count wraps.
`timescale 1ns/1ps
`default_nettype none
module atp_counter #(
  parameter int WIDTH = atp_pkg::CNT_WIDTH
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] reload,
  input  wire logic             tick,
  input  wire logic             gate,
  // Status
  output logic      [WIDTH-1:0] count,
  output logic                  terminal
);

  // A one-bit counter cannot hold a reload above one
  if (WIDTH < 2) begin : g_width_check
    $error("atp_counter: WIDTH too small");
  end

  wire              step       = tick & gate;
  wire              atOne      = (count <= WIDTH'(1));
  wire [WIDTH-1:0]  next_count = load ? reload :
                                 (step ? (atOne ? reload : count - WIDTH'(1)) : count);
  wire              next_term  = step & atOne & ~load;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count    <= WIDTH'(atp_pkg::RST_COUNT);
      terminal <= 1'b0;
    end else begin
      count    <= next_count;
      terminal <= next_term;
    end
  end

endmodule
`default_nettype wire

//--- hdl/atp_pacer.sv
// Purpose: Conversion trigger pacer with general counter and ext trigger.
// Assumes: All pins synchronous to sys_clk in name; synchronised anyway.
// Notes:   Pacer pin pulses one cycle; counter zero toggles in pulse mode.
`timescale 1ns/1ps
`default_nettype none
module atp_pacer #(
  parameter int WIDTH = atp_pkg::CNT_WIDTH
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  // Counter configuration
  input  wire atp_pkg::atp_cnt_cfg_t cnt0Cfg,
  input  wire atp_pkg::atp_cnt_cfg_t cnt1Cfg,
  input  wire atp_pkg::atp_cnt_cfg_t cnt2Cfg,
  input  wire atp_pkg::atp_mode_t    cnt0Mode,
  input  wire logic                  cnt0ExtClkSel,
  // Trigger source enables
  input  wire logic                  pacerEnable,
  input  wire logic                  extTrigEnable,
  // Channel selection
  input  wire atp_pkg::atp_chan_cfg_t chanReq,
  // External pins
  input  wire logic                  ext_trigger_gate,
  input  wire logic                  ext_trigger_in,
  input  wire logic                  counter_zero_clock_in,
  input  wire logic                  counter_zero_gate_in,
  output logic                       counter_zero_out,
  output logic                       pacerOut,
  // Conversion side
  output logic                       convStart,
  output atp_pkg::atp_chan_cfg_t     chanSel,
  output logic [WIDTH-1:0]           cnt0Count
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int SYNC = atp_pkg::SYNC_STAGES;

  // Pin widths and the 32-bit chain assume 16-bit counters
  if (WIDTH != atp_pkg::CNT_WIDTH) begin : g_width_check
    $error("atp_pacer: counters are 16 bits");
  end

  // A single stage would pass metastable levels to the edge logic
  if (SYNC < 2) begin : g_sync_check
    $error("atp_pacer: at least two synchroniser stages");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Low-to-high step between two successive settled samples
  function automatic logic rising(input logic cur, input logic last);
    return cur & ~last;
  endfunction

  // Differential pairs reach only the lower half of the codes
  function automatic logic chan_legal(input atp_pkg::atp_chan_cfg_t req);
    return ~req.differential | (req.channel < 4'(atp_pkg::CHAN_DIFF));
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Cabled sources are asynchronous whatever the pin list says
  logic [SYNC-1:0] trgSync;
  logic [SYNC-1:0] gateSync;
  logic [SYNC-1:0] c0ClkSync;
  logic [SYNC-1:0] c0GateSync;
  logic            trgLast;
  logic            c0ClkLast;

  // Only the last stage of each chain is read
  wire trgNow    = trgSync[SYNC-1];
  wire gateNow   = gateSync[SYNC-1];
  wire c0ClkNow  = c0ClkSync[SYNC-1];
  wire c0GateNow = c0GateSync[SYNC-1];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trgSync <= '0;
    end else begin
      trgSync <= {trgSync[SYNC-2:0], ext_trigger_in};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gateSync <= '0;
    end else begin
      gateSync <= {gateSync[SYNC-2:0], ext_trigger_gate};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      c0ClkSync <= '0;
    end else begin
      c0ClkSync <= {c0ClkSync[SYNC-2:0], counter_zero_clock_in};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      c0GateSync <= '0;
    end else begin
      c0GateSync <= {c0GateSync[SYNC-2:0], counter_zero_gate_in};
    end
  end

  // Last settled levels, reset to the idle low of both pins
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trgLast   <= 1'b0;
      c0ClkLast <= 1'b0;
    end else begin
      trgLast   <= trgNow;
      c0ClkLast <= c0ClkNow;
    end
  end

  // ----------------------------------------------------------------
  // Trigger qualification
  // ----------------------------------------------------------------
  // gate low blocks trigger
  wire extAllowed = gateNow & extTrigEnable;
  wire extEdge    = rising(trgNow, trgLast) & extAllowed;
  // Count clock uses the same detector as the trigger
  wire c0ExtTick  = rising(c0ClkNow, c0ClkLast);

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  wire [WIDTH-1:0] cnt1Count;
  wire [WIDTH-1:0] cnt2Count;
  wire             term0;
  wire             term1;
  wire             term2;

  wire c0Tick = cnt0ExtClkSel ? c0ExtTick : 1'b1;

  atp_counter #(.WIDTH(WIDTH)) u_cnt0 (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .load     (cnt0Cfg.load),
    .reload   (cnt0Cfg.reload),
    .tick     (c0Tick),
    .gate     (c0GateNow),
    .count    (cnt0Count),
    .terminal (term0)
  );

  atp_counter #(.WIDTH(WIDTH)) u_cnt1 (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .load     (cnt1Cfg.load),
    .reload   (cnt1Cfg.reload),
    .tick     (pacerEnable),
    .gate     (1'b1),
    .count    (cnt1Count),
    .terminal (term1)
  );

  atp_counter #(.WIDTH(WIDTH)) u_cnt2 (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .load     (cnt2Cfg.load),
    .reload   (cnt2Cfg.reload),
    .tick     (term1),
    .gate     (pacerEnable),
    .count    (cnt2Count),
    .terminal (term2)
  );

  // ----------------------------------------------------------------
  // Outputs and conversion start
  // ----------------------------------------------------------------
  // Pulse mode toggles, event mode shows terminal only
  wire next_c0Out = (cnt0Mode == atp_pkg::ATP_MODE_PULSE) ?
                    (counter_zero_out ^ term0) : term0;
  // Pacer high for one cycle per period, so each period gives one edge
  wire next_pacer = term2 & pacerEnable;
  wire pacerRise  = rising(next_pacer, pacerOut);
  // A pacer edge and a trigger edge in one cycle give a single start
  wire next_start = pacerRise | extEdge;

  wire chanOk     = chan_legal(chanReq);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      counter_zero_out <= 1'b0;
    end else begin
      counter_zero_out <= next_c0Out;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pacerOut <= 1'b0;
    end else begin
      pacerOut <= next_pacer;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      convStart <= 1'b0;
    end else begin
      convStart <= next_start;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      chanSel <= '{differential: 1'b0, channel: atp_pkg::RST_CHAN};
    end else if (chanOk) begin
      chanSel <= chanReq;
    end
  end

endmodule
`default_nettype wire

//--- bench/atp_checker.sv
// Purpose: Port checks of the trigger pacer
// Assumes: Pacer reloads 2 and 3, counter zero reload 4
// Notes:   Bound into every atp_pacer
`timescale 1ns/1ps
`default_nettype none
module atp_checker (
  // Clock and controls
  input wire logic                   sys_clk,
  input wire logic                   rst_b,
  input wire atp_pkg::atp_cnt_cfg_t  cnt0Cfg,
  input wire atp_pkg::atp_mode_t     cnt0Mode,
  input wire logic                   pacerEnable,
  input wire logic                   extTrigEnable,
  input wire atp_pkg::atp_chan_cfg_t chanReq,
  // Pins and results
  input wire logic                   ext_trigger_gate,
  input wire logic                   ext_trigger_in,
  input wire logic                   counter_zero_gate_in,
  input wire logic                   counter_zero_out,
  input wire logic                   pacerOut,
  input wire logic                   convStart,
  input wire atp_pkg::atp_chan_cfg_t chanSel,
  input wire logic [15:0]            cnt0Count
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire bad = chanReq.differential && chanReq.channel[3];
  property p_one; convStart |=> !convStart; endproperty
  a_one: assert property (p_one) else $error("start pulse too long");
  property p_pac; $rose(pacerOut) |-> convStart; endproperty
  a_pac: assert property (p_pac) else $error("pacer edge gave no start");
  property p_ext;
    $rose(ext_trigger_in) && ext_trigger_gate && extTrigEnable |-> ##3 convStart;
  endproperty
  a_ext: assert property (p_ext) else $error("trigger edge gave no start");
  property p_gate; (!ext_trigger_gate && !pacerEnable)[*6] |-> !convStart; endproperty
  a_gate: assert property (p_gate) else $error("start while gate low");
  property p_dis; (!extTrigEnable && !pacerEnable)[*4] |-> !convStart; endproperty
  a_dis: assert property (p_dis) else $error("start while trigger disabled");
  property p_per; pacerOut |=> !pacerOut[*5] ##1 (pacerOut || !pacerEnable); endproperty
  a_per: assert property (p_per) else $error("pacer period wrong");
  property p_ev;
    cnt0Mode == atp_pkg::ATP_MODE_EVENT && counter_zero_out |=> !counter_zero_out;
  endproperty
  a_ev: assert property (p_ev) else $error("event output too long");
  property p_frz; (!counter_zero_gate_in && !cnt0Cfg.load)[*4] |=> $stable(cnt0Count);
  endproperty
  a_frz: assert property (p_frz) else $error("count moved, gate low");
  property p_rej; bad |=> $stable(chanSel); endproperty
  a_rej: assert property (p_rej) else $error("bad channel taken");
  property p_acc; !bad |=> chanSel == $past(chanReq); endproperty
  a_acc: assert property (p_acc) else $error("channel not taken");
  c_ext: cover property (convStart && !pacerEnable);
  c_pac: cover property ($rose(pacerOut));
  c_rej: cover property (bad);
endmodule
bind atp_pacer atp_checker i_chk (.sys_clk, .rst_b, .cnt0Cfg, .cnt0Mode, .pacerEnable,
  .extTrigEnable, .chanReq, .ext_trigger_gate, .ext_trigger_in, .counter_zero_gate_in,
  .counter_zero_out, .pacerOut, .convStart, .chanSel, .cnt0Count);
`default_nettype wire

//--- bench/atp_far_side.sv
// Purpose: External trigger, gate and counter sources
// Assumes: Bench calls tasks just after a rising edge
// Notes:   Counter clock stands still between bursts
`timescale 1ns/1ps
`default_nettype none
module atp_far_side (
  // Clock
  input  wire logic sys_clk,
  // Pins
  output logic      ext_trigger_gate,
  output logic      ext_trigger_in,
  output logic      counter_zero_clock_in,
  output logic      counter_zero_gate_in
);
  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  initial begin
    ext_trigger_gate = 1'b0;
    ext_trigger_in = 1'b0;
    counter_zero_clock_in = 1'b0;
    counter_zero_gate_in = 1'b1;
  end
  task automatic set_pins(input logic g, input logic c0g);
    ext_trigger_gate = g;
    counter_zero_gate_in = c0g;
  endtask
  // Held 3 cycles so two sync stages see it
  task automatic trig_edge();
    ext_trigger_in = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 ext_trigger_in = 1'b0;
  endtask
  task automatic clk_edges(input int n);
    repeat (n) begin
      counter_zero_clock_in = ~counter_zero_clock_in;
      repeat (2) @(posedge sys_clk);
      #1;
    end
  endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
// Purpose: Self-checking bench of the trigger pacer
// Assumes: Outputs read 1 ns after each rising edge
// Notes:   Periods measured between rises, not from reset
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                   sys_clk, rst_b, cnt0ExtClkSel, pacerEnable, extTrigEnable;
  logic                   ext_trigger_gate, ext_trigger_in, counter_zero_clock_in;
  logic                   counter_zero_gate_in, counter_zero_out, pacerOut, convStart;
  logic [15:0]            cnt0Count;
  atp_pkg::atp_cnt_cfg_t  cnt0Cfg, cnt1Cfg, cnt2Cfg;
  atp_pkg::atp_mode_t     cnt0Mode;
  atp_pkg::atp_chan_cfg_t chanReq, chanSel;
  int                     num_errors = 0, n_tests = 0, cyc = 0;
  wire [2:0]              obs = {counter_zero_out, pacerOut, convStart};
  atp_pacer i_atp_pacer (.sys_clk, .rst_b, .cnt0Cfg, .cnt1Cfg, .cnt2Cfg, .cnt0Mode,
    .cnt0ExtClkSel, .pacerEnable, .extTrigEnable, .chanReq, .ext_trigger_gate,
    .ext_trigger_in, .counter_zero_clock_in, .counter_zero_gate_in, .counter_zero_out,
    .pacerOut, .convStart, .chanSel, .cnt0Count);
  atp_far_side i_atp_far_side (.sys_clk, .ext_trigger_gate, .ext_trigger_in,
    .counter_zero_clock_in, .counter_zero_gate_in);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  always #2 sys_clk = ~sys_clk;
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  task automatic rise_gap(input int s, output int g);
    int k;
    logic p;
    k = 0;
    g = 0;
    p = 1'b1;
    for (int i = 0; i < 300 && k < 2; i++) begin
      if (k == 1) g++;
      if (obs[s] === 1'b1 && p !== 1'b1) k++;
      p = obs[s];
      step(1);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_ext(input logic g, input logic en);
    int n, lat;
    n = 0;
    lat = 0;
    extTrigEnable = en;
    i_atp_far_side.set_pins(g, 1'b1);
    step(8);
    fork
      i_atp_far_side.trig_edge();
      for (int k = 1; k <= 10; k++) begin
        step(1);
        if (convStart === 1'b1) begin
          n++;
          lat = k;
        end
      end
    join
    chk(n, g & en);
    chk(lat, (g & en) ? 3 : 0);
    extTrigEnable = 1'b1;
  endtask
  task automatic t_pacer();
    int g;
    pacerEnable = 1'b1;
    rise_gap(1, g);
    chk(g, 6);
    rise_gap(0, g);
    chk(g, 6);
    pacerEnable = 1'b0;
  endtask
  task automatic t_chan();
    logic [4:0] req [4] = '{5'h0F, 5'h09, 5'h19, 5'h17};
    logic [4:0] want [4] = '{5'h0F, 5'h09, 5'h09, 5'h17};
    for (int i = 0; i < 4; i++) begin
      chanReq = req[i];
      step(2);
      chk(chanSel, want[i]);
    end
  endtask
  task automatic t_cnt0();
    int g;
    logic [15:0] c;
    rise_gap(2, g);
    chk(g, 4);
    i_atp_far_side.set_pins(1'b0, 1'b0);
    step(4);
    c = cnt0Count;
    step(8);
    chk(cnt0Count, c);
    i_atp_far_side.set_pins(1'b0, 1'b1);
    cnt0Mode = atp_pkg::ATP_MODE_PULSE;
    rise_gap(2, g);
    chk(g, 8);
    cnt0ExtClkSel = 1'b1;
    fork
      i_atp_far_side.clk_edges(70);
      rise_gap(2, g);
    join
    chk(g, 32);
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    cnt0ExtClkSel = 1'b0;
    pacerEnable = 1'b0;
    extTrigEnable = 1'b1;
    cnt0Mode = atp_pkg::ATP_MODE_EVENT;
    chanReq = '0;
    cnt0Cfg = '{16'h0004, 1'b1};
    cnt1Cfg = '{16'h0002, 1'b1};
    cnt2Cfg = '{16'h0003, 1'b1};
    step(6);
    rst_b = 1'b1;
    step(2);
    cnt0Cfg.load = 1'b0;
    cnt1Cfg.load = 1'b0;
    cnt2Cfg.load = 1'b0;
    t_ext(1'b1, 1'b1);
    t_ext(1'b0, 1'b1);
    t_ext(1'b1, 1'b0);
    t_pacer();
    t_chan();
    t_cnt0();
    finish_test();
  end
endmodule
`default_nettype wire
